// [common/rssr_pkg.sv]
// Package for the reference switch stop and ramp status block.
// Assumes a single 125 MHz clock and an APB register port.
package rssr_pkg;

  // Register word indices (printed offsets not all multiples of four)
  localparam logic [7:0] RSSR_IDX_CFG = 8'h34;
  localparam logic [7:0] RSSR_IDX_STAT = 8'h35;
  localparam logic [7:0] RSSR_IDX_LATCH = 8'h36;
  localparam logic [7:0] RSSR_IDX_IRQ_STAT = 8'h37;
  localparam logic [7:0] RSSR_IDX_IRQ_MASK = 8'h38;
  localparam logic [7:0] RSSR_IDX_CUR_POS = 8'h39;
  localparam logic [7:0] RSSR_IDX_GOAL_POS = 8'h3A;

  // Configuration fields
  localparam int RSSR_CFG_STOP_L = 0;
  localparam int RSSR_CFG_STOP_R = 1;
  localparam int RSSR_CFG_POL_L = 2;
  localparam int RSSR_CFG_POL_R = 3;
  localparam int RSSR_CFG_SWAP = 4;
  localparam int RSSR_CFG_LATCH_L_ACT = 5;
  localparam int RSSR_CFG_LATCH_L_INACT = 6;
  localparam logic [11:0] RSSR_CFG_RESET = 12'h000;
  localparam logic [11:0] RSSR_CFG_WMASK = 12'h07F;

  // Status fields
  localparam int RSSR_ST_LEFT = 0;
  localparam int RSSR_ST_RIGHT = 1;
  localparam int RSSR_ST_LATCH_L = 2;
  localparam int RSSR_ST_POS_REACHED = 9;
  localparam int RSSR_ST_ZEROWAIT = 11;
  localparam int RSSR_ST_SECOND_MOVE = 12;
  localparam int RSSR_ST_STALL = 13;

  // Interrupt event bits
  localparam int RSSR_EV_LATCH = 0;
  localparam int RSSR_EV_REVERSAL = 1;
  localparam int RSSR_EV_STOP = 2;
  localparam logic [2:0] RSSR_EV_RESET = 3'h0;

  localparam logic [31:0] RSSR_POS_RESET = 32'h0000_0000;

  // Switch levels after polarity and swap
  typedef struct packed {
    logic left;
    logic right;
  } rssr_sw_t;

endpackage : rssr_pkg

// [verif/rssr_sw_model.sv]
// Model of the left and right mechanical reference switches.
// Assumes the bench changes commands right after a rising clock edge.
module rssr_sw_model (
  input wire logic clk_i,
  input wire logic left_cmd_i,
  input wire logic right_cmd_i,
  output logic left_o,
  output logic right_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contacts settle one clock after the command; always driven, no float
  always @(posedge clk_i) begin
    left_o <= left_cmd_i;
    right_o <= right_cmd_i;
  end
endmodule : rssr_sw_model

// [verif/tb.sv]
// Self-checking bench for the switch stop and ramp status block.
// Assumes zero-wait APB slave; switch levels come from the switch model.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] I_CFG = rssr_pkg::RSSR_IDX_CFG;
  localparam logic [7:0] I_ST = rssr_pkg::RSSR_IDX_STAT;
  localparam logic [7:0] I_LAT = rssr_pkg::RSSR_IDX_LATCH;
  localparam logic [7:0] I_IST = rssr_pkg::RSSR_IDX_IRQ_STAT;
  localparam logic [7:0] I_MSK = rssr_pkg::RSSR_IDX_IRQ_MASK;
  typedef struct packed {logic [6:0] cfg; logic l; logic r; logic [1:0] st; logic stop;} rssr_tb_row_t;
  logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, v;
  logic pready, pslverr, sw_stop, irq, left_ref, right_ref, e;
  logic left_cmd = 1'h0, right_cmd = 1'h0, stall = 1'h0, rev = 1'h0, zwait = 1'h0;
  logic [31:0] cur_pos = 32'h1000, goal_pos = 32'h2000;
  int err_total = 0;
  int cmp_count = 0;
  // Swap picks the input first, polarity then acts on the logical side
  rssr_tb_row_t rows [9] = '{'{7'h00, 1'h1, 1'h0, 2'h1, 1'h0}, '{7'h00, 1'h0, 1'h1, 2'h2, 1'h0},
    '{7'h04, 1'h0, 1'h0, 2'h1, 1'h0}, '{7'h08, 1'h1, 1'h1, 2'h1, 1'h0}, '{7'h01, 1'h1, 1'h0, 2'h1, 1'h1},
    '{7'h01, 1'h0, 1'h0, 2'h0, 1'h0}, '{7'h02, 1'h0, 1'h1, 2'h2, 1'h1}, '{7'h11, 1'h0, 1'h1, 2'h1, 1'h1},
    '{7'h12, 1'h0, 1'h1, 2'h1, 1'h0}};
  ////////////////////////////////////////////////////////////////////////////
  always #4 clk = ~clk;
  rssr_sw_model rssr_sw_model_i (.clk_i(clk), .left_cmd_i(left_cmd), .right_cmd_i(right_cmd),
    .left_o(left_ref), .right_o(right_ref));
  rssr_top rssr_top_i (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .left_ref_input_i(left_ref), .right_ref_input_i(right_ref), .stall_i(stall), .reversal_i(rev),
    .zerowait_active_i(zwait), .current_position_i(cur_pos), .goal_position_i(goal_pos),
    .switch_stop_o(sw_stop), .irq_o(irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // One APB transfer; entered right after a rising edge, request held until pready
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      err_total++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    logic er;
    apb(1'h1, idx, d, x, er);
  endtask : wr
  task automatic sw(input logic l, input logic r);
    left_cmd <= l;
    right_cmd <= r;
    repeat (2) @(posedge clk);
  endtask : sw
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    apb(1'h0, I_CFG, 32'h0, v, e);
    chk(v, 32'h0);
    apb(1'h0, I_LAT, 32'h0, v, e);
    chk(v, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(I_CFG, 32'hFFFF_FF83);
    apb(1'h0, I_CFG, 32'h0, v, e);
    chk(v, 32'h3);
    apb(1'h0, 8'h40, 32'h0, v, e);
    chk({v[30:0], e}, 32'h1);
    // Unmapped write is refused and leaves the config alone
    apb(1'h1, 8'h40, 32'h1, v, e);
    chk({31'h0, e}, 32'h1);
    apb(1'h0, I_CFG, 32'h0, v, e);
    chk({v[30:0], e}, 32'h6);
    // Position words read back as presented
    apb(1'h0, rssr_pkg::RSSR_IDX_CUR_POS, 32'h0, v, e);
    chk(v, 32'h1000);
    apb(1'h0, rssr_pkg::RSSR_IDX_GOAL_POS, 32'h0, v, e);
    chk(v, 32'h2000);
    // Ordinary switch cases, one row each
    foreach (rows[i]) begin
      wr(I_CFG, {25'h0, rows[i].cfg});
      sw(rows[i].l, rows[i].r);
      apb(1'h0, I_ST, 32'h0, v, e);
      chk(v, {30'h0, rows[i].st});
      chk({31'h0, sw_stop}, {31'h0, rows[i].stop});
    end
    wr(I_CFG, 32'h0);
    sw(1'h0, 1'h0);
    stall <= 1'h1; // Live stall level, polled here only as a
    zwait <= 1'h1;
    goal_pos <= cur_pos;
    @(posedge clk);
    apb(1'h0, I_ST, 32'h0, v, e);
    chk(v, 32'h2A00);
    stall <= 1'h0;
    zwait <= 1'h0;
    goal_pos <= 32'h2000;
    rev <= 1'h1;
    @(posedge clk);
    rev <= 1'h0;
    @(posedge clk);
    apb(1'h0, I_ST, 32'h0, v, e);
    chk(v, 32'h1000);
    apb(1'h0, I_ST, 32'h0, v, e);
    chk(v, 32'h0);
    // Event lands on the very edge of the clearing read
    fork
      apb(1'h0, I_ST, 32'h0, v, e);
      begin
        @(posedge clk);
        rev <= 1'h1;
        @(posedge clk);
        rev <= 1'h0;
      end
    join
    apb(1'h0, I_ST, 32'h0, v, e);
    chk(v, 32'h1000);
    wr(I_CFG, 32'h20);
    cur_pos <= 32'hABC;
    sw(1'h1, 1'h0);
    apb(1'h0, I_LAT, 32'h0, v, e);
    chk(v, 32'hABC);
    apb(1'h0, I_ST, 32'h0, v, e);
    chk(v, 32'h5);
    apb(1'h0, I_ST, 32'h0, v, e);
    chk(v, 32'h1);
    cur_pos <= 32'hDEF;
    sw(1'h0, 1'h0);
    wr(I_CFG, 32'h40);
    sw(1'h1, 1'h0);
    apb(1'h0, I_LAT, 32'h0, v, e);
    chk(v, 32'hABC);
    cur_pos <= 32'h123;
    sw(1'h0, 1'h0);
    apb(1'h0, I_LAT, 32'h0, v, e);
    chk(v, 32'h123);
    // Interrupt: latch event masked, unmasked, then cleared by write-one
    chk({31'h0, irq}, 32'h0);
    wr(I_MSK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'h0, I_MSK, 32'h0, v, e);
    chk(v, 32'h1);
    wr(I_IST, 32'h7);
    chk({31'h0, irq}, 32'h0);
    apb(1'h0, I_IST, 32'h0, v, e);
    chk(v, 32'h0);
    rev <= 1'h1;
    @(posedge clk);
    rev <= 1'h0;
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'h0, I_IST, 32'h0, v, e);
    chk(v, 32'h2);
    // Reset in mid-run with a stop and a capture pending
    wr(I_CFG, 32'h21);
    cur_pos <= 32'h456;
    sw(1'h1, 1'h0);
    chk({31'h0, sw_stop}, 32'h1);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    chk({31'h0, sw_stop}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'h0, I_CFG, 32'h0, v, e);
    chk(v, 32'h0);
    apb(1'h0, I_LAT, 32'h0, v, e);
    chk(v, 32'h0);
    apb(1'h0, I_IST, 32'h0, v, e);
    chk(v, 32'h0);
    apb(1'h0, I_MSK, 32'h0, v, e);
    chk(v, 32'h0);
    apb(1'h0, I_ST, 32'h0, v, e);
    chk(v, 32'h1);
    test_done();
  end
endmodule : tb

// [verilog/rssr_top.sv]
// Reference switch stop, position capture and ramp status logic.
// Assumes APB master on clk_i, switch inputs already synchronous.
module rssr_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic left_ref_input_i,
  input wire logic right_ref_input_i,
  input wire logic stall_i,
  input wire logic reversal_i,
  input wire logic zerowait_active_i,
  input wire logic [31:0] current_position_i,
  input wire logic [31:0] goal_position_i,
  output logic switch_stop_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////
  // Bus decode
  logic access;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic mapped;
  assign access = psel_i & penable_i;
  assign wr = access & pwrite_i;
  assign rd = access & ~pwrite_i;
  assign idx = paddr_i[9:2];
  assign pready_o = 1'b1;
  assign mapped = (paddr_i[31:10] == 22'h0) && (paddr_i[1:0] == 2'h0) &&
                  (idx >= rssr_pkg::RSSR_IDX_CFG) && (idx <= rssr_pkg::RSSR_IDX_GOAL_POS);
  assign pslverr_o = access & ~mapped;

  ////////////////////////////////////////////////////////////////
  // Switch conditioning
  logic [11:0] cfg_reg;
  logic [11:0] cfg_next;
  rssr_pkg::rssr_sw_t raw;
  rssr_pkg::rssr_sw_t act;
  // Swap happens before polarity so polarity follows the logical side
  always_comb begin
    raw.left = cfg_reg[rssr_pkg::RSSR_CFG_SWAP] ? right_ref_input_i : left_ref_input_i;
    raw.right = cfg_reg[rssr_pkg::RSSR_CFG_SWAP] ? left_ref_input_i : right_ref_input_i;
    act.left = raw.left ^ cfg_reg[rssr_pkg::RSSR_CFG_POL_L];
    act.right = raw.right ^ cfg_reg[rssr_pkg::RSSR_CFG_POL_R];
  end

  // Stop is a level; releasing the switch lets motion resume
  assign switch_stop_o = (act.left & cfg_reg[rssr_pkg::RSSR_CFG_STOP_L]) |
                         (act.right & cfg_reg[rssr_pkg::RSSR_CFG_STOP_R]);

  ////////////////////////////////////////////////////////////////
  // State: config, previous left level, capture, flags, interrupt events and mask
  logic prev_left_reg;
  logic prev_left_next;
  logic [31:0] capture_reg;
  logic [31:0] capture_next;
  logic latch_flag_reg;
  logic latch_flag_next;
  logic rev_flag_reg;
  logic rev_flag_next;
  logic [2:0] ev_reg;
  logic [2:0] ev_next;
  logic [2:0] mask_reg;
  logic [2:0] mask_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic latch_evt;
  logic stat_rd;
  logic [13:0] status;
  logic [2:0] ev_set;

  // Edge detect on the conditioned left level
  always_comb begin
    latch_evt = (act.left & ~prev_left_reg & cfg_reg[rssr_pkg::RSSR_CFG_LATCH_L_ACT]) |
                (~act.left & prev_left_reg & cfg_reg[rssr_pkg::RSSR_CFG_LATCH_L_INACT]);
  end

  assign stat_rd = rd && mapped && (idx == rssr_pkg::RSSR_IDX_STAT);

  // Status word assembly
  always_comb begin
    status = 14'h0000;
    status[rssr_pkg::RSSR_ST_LEFT] = act.left;
    status[rssr_pkg::RSSR_ST_RIGHT] = act.right;
    status[rssr_pkg::RSSR_ST_LATCH_L] = latch_flag_reg;
    status[rssr_pkg::RSSR_ST_POS_REACHED] = (current_position_i == goal_position_i);
    status[rssr_pkg::RSSR_ST_ZEROWAIT] = zerowait_active_i;
    status[rssr_pkg::RSSR_ST_SECOND_MOVE] = rev_flag_reg;
    status[rssr_pkg::RSSR_ST_STALL] = stall_i;
  end

  always_comb begin
    ev_set = 3'h0;
    ev_set[rssr_pkg::RSSR_EV_LATCH] = latch_evt;
    ev_set[rssr_pkg::RSSR_EV_REVERSAL] = reversal_i;
    ev_set[rssr_pkg::RSSR_EV_STOP] = switch_stop_o;
  end

  // Next state; sets are ORed after clears so events are never lost
  always_comb begin
    cfg_next = cfg_reg;
    mask_next = mask_reg;
    ev_next = ev_reg;
    prev_left_next = act.left;
    capture_next = capture_reg;
    latch_flag_next = latch_flag_reg;
    rev_flag_next = rev_flag_reg;
    prdata_next = prdata_reg;
    if (wr && mapped) begin
      if (idx == rssr_pkg::RSSR_IDX_CFG) begin
        cfg_next = pwdata_i[11:0] & rssr_pkg::RSSR_CFG_WMASK;
      end else if (idx == rssr_pkg::RSSR_IDX_IRQ_STAT) begin
        ev_next = ev_reg & ~pwdata_i[2:0];
      end else if (idx == rssr_pkg::RSSR_IDX_IRQ_MASK) begin
        mask_next = pwdata_i[2:0];
      end
    end
    if (stat_rd) begin
      latch_flag_next = 1'b0;
      rev_flag_next = 1'b0;
    end
    if (latch_evt) begin
      capture_next = current_position_i;
      latch_flag_next = 1'b1;
    end
    if (reversal_i) begin
      rev_flag_next = 1'b1;
    end
    ev_next = ev_next | ev_set;
    if (rd && mapped) begin
      if (idx == rssr_pkg::RSSR_IDX_CFG) begin
        prdata_next = {20'h00000, cfg_reg};
      end else if (idx == rssr_pkg::RSSR_IDX_STAT) begin
        prdata_next = {18'h00000, status};
      end else if (idx == rssr_pkg::RSSR_IDX_LATCH) begin
        prdata_next = capture_reg;
      end else if (idx == rssr_pkg::RSSR_IDX_IRQ_STAT) begin
        prdata_next = {29'h00000000, ev_reg};
      end else if (idx == rssr_pkg::RSSR_IDX_IRQ_MASK) begin
        prdata_next = {29'h00000000, mask_reg};
      end else if (idx == rssr_pkg::RSSR_IDX_CUR_POS) begin
        prdata_next = current_position_i;
      end else begin
        prdata_next = goal_position_i;
      end
    end else if (rd) begin
      prdata_next = 32'h00000000;
    end
  end

  // Registers only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_reg <= rssr_pkg::RSSR_CFG_RESET;
      mask_reg <= rssr_pkg::RSSR_EV_RESET;
      ev_reg <= rssr_pkg::RSSR_EV_RESET;
      prev_left_reg <= 1'b0;
      capture_reg <= rssr_pkg::RSSR_POS_RESET;
      latch_flag_reg <= 1'b0;
      rev_flag_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      cfg_reg <= cfg_next;
      mask_reg <= mask_next;
      ev_reg <= ev_next;
      prev_left_reg <= prev_left_next;
      capture_reg <= capture_next;
      latch_flag_reg <= latch_flag_next;
      rev_flag_reg <= rev_flag_next;
      prdata_reg <= prdata_next;
    end
  end

  // Zero-wait slave: read data must stand in the access cycle itself, so the
  // bus sees the next value; a registered copy would need one wait state and
  // would return the same status; a same-cycle set shows on the next read
  always_comb begin
    prdata_o = prdata_next;
  end

  assign irq_o = |(ev_reg & mask_reg);

  ////////////////////////////////////////////////////////////////
  // Checks
  property p_latch_capture;
    @(posedge clk_i) disable iff (!rst_n_i)
      latch_evt |=> (capture_reg == $past(current_position_i)) && latch_flag_reg;
  endproperty
  a_latch_capture: assert property (p_latch_capture) else $error("capture missed");

  // Edge rebuilt from the pin and its last value, not from the edge register
  property p_act_edge;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cfg_reg[rssr_pkg::RSSR_CFG_LATCH_L_ACT] && !cfg_reg[rssr_pkg::RSSR_CFG_SWAP] && $stable(cfg_reg) &&
       ($past(left_ref_input_i) == cfg_reg[rssr_pkg::RSSR_CFG_POL_L]) &&
       (left_ref_input_i != cfg_reg[rssr_pkg::RSSR_CFG_POL_L])) |-> latch_evt;
  endproperty
  a_act_edge: assert property (p_act_edge) else $error("active edge no latch");

  property p_inact_edge;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cfg_reg[rssr_pkg::RSSR_CFG_LATCH_L_INACT] && !cfg_reg[rssr_pkg::RSSR_CFG_SWAP] && $stable(cfg_reg) &&
       ($past(left_ref_input_i) != cfg_reg[rssr_pkg::RSSR_CFG_POL_L]) &&
       (left_ref_input_i == cfg_reg[rssr_pkg::RSSR_CFG_POL_L])) |-> latch_evt;
  endproperty
  a_inact_edge: assert property (p_inact_edge) else $error("inactive edge no latch");

  property p_no_edge;
    @(posedge clk_i) disable iff (!rst_n_i)
      (!cfg_reg[rssr_pkg::RSSR_CFG_LATCH_L_ACT] && !cfg_reg[rssr_pkg::RSSR_CFG_LATCH_L_INACT]) |-> !latch_evt;
  endproperty
  a_no_edge: assert property (p_no_edge) else $error("latch while disabled");

  property p_stop_left;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cfg_reg[rssr_pkg::RSSR_CFG_STOP_L] && !cfg_reg[rssr_pkg::RSSR_CFG_SWAP] &&
       (left_ref_input_i != cfg_reg[rssr_pkg::RSSR_CFG_POL_L])) |-> switch_stop_o;
  endproperty
  a_stop_left: assert property (p_stop_left) else $error("left stop missing");

  property p_stop_right_swap;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cfg_reg[rssr_pkg::RSSR_CFG_STOP_R] && cfg_reg[rssr_pkg::RSSR_CFG_SWAP] &&
       (left_ref_input_i != cfg_reg[rssr_pkg::RSSR_CFG_POL_R])) |-> switch_stop_o;
  endproperty
  a_stop_right_swap: assert property (p_stop_right_swap) else $error("swap stop missing");

  property p_release;
    @(posedge clk_i) disable iff (!rst_n_i)
      (!act.left && !act.right) |-> !switch_stop_o;
  endproperty
  a_release: assert property (p_release) else $error("stop without switch");

  property p_rev_sticky;
    @(posedge clk_i) disable iff (!rst_n_i)
      reversal_i |=> rev_flag_reg;
  endproperty
  a_rev_sticky: assert property (p_rev_sticky) else $error("reversal lost");

  property p_read_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
      (stat_rd && !reversal_i) |=> !rev_flag_reg;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("reversal not cleared");

  property p_pos_match;
    @(posedge clk_i) disable iff (!rst_n_i)
      (current_position_i == goal_position_i) |-> status[rssr_pkg::RSSR_ST_POS_REACHED];
  endproperty
  a_pos_match: assert property (p_pos_match) else $error("position flag wrong");

endmodule : rssr_top
